// file: rtl/frup_top.sv
/*
 * Fault record upload: command interpreter of the management link with the
 * event recorder, usage statistics, ordering code read and loader hand-over.
 * Assumes a byte-level link front end, synchronous to SYS_CLK_I, that has
 * already matched the device address and pulls answer bytes from a FIFO.
 */
`include "frup_regs.svh"
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Answer FIFO
// ----------------------------------------------------------------------
module frup_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             flush_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             push, pop;

   always_comb begin
      push        = in_valid_i && (count != AW'(0) + (AW+1)'(DEPTH)) && !flush_i;
      pop         = out_valid_o && out_ready_i && !flush_i;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
      if (flush_i) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count  = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
endmodule

// ----------------------------------------------------------------------
// Command interpreter and recorder
// ----------------------------------------------------------------------
module frup_top #(
   parameter logic [6:0]  DEV_ADDR   = 7'h58,
   parameter logic [87:0] ORDER_CODE = 88'h3030303030303030303031, // Arbitrary value.
   parameter int          TICK_CYC   = `FRUP_TICK_CYC,
   parameter int          FIFO_DEPTH = 16
) (
   input  wire logic                      SYS_CLK_I,
   input  wire logic                      RST_I,
   input  wire frup_pkg::frup_link_type   LINK_I,
   output logic                           TX_VALID_O,
   input  wire logic                      TX_READY_I,
   output logic [7:0]                     TX_DATA_O,
   input  wire logic                      FAULT_REC_I,
   input  wire logic                      FAULT_NONREC_I,
   input  wire frup_pkg::frup_snap_in_type SNAP_I,
   input  wire logic [2:0]                LOAD_BIN_I,
   output logic                           SNAP_STORED_O,
   input  wire logic                      BOOT_ENTER_I,
   input  wire logic                      BOOT_ERR_I,
   input  wire logic                      BOOT_EXIT_I,
   output logic                           APP_RUN_O
);
   // Recorder storage and statistics.
   frup_pkg::frup_record_type rec [5];
   logic [31:0] bin_time [`FRUP_BINS];
   logic [15:0] occ_rec, occ_nonrec, next_occ_rec, next_occ_nonrec;
   logic [2:0]  wr_idx, next_wr_idx, rec_cnt, next_rec_cnt;
   logic [31:0] stamp, next_stamp;
   logic [31:0] tick, next_tick;
   logic        trig, next_stored;

   // Command state.
   frup_pkg::frup_state_type state, next_state;
   logic [7:0]  cmd, next_cmd, len, next_len, idx, next_idx, crc, next_crc;
   logic [15:0] addr, next_addr;
   logic [1:0]  arg_cnt, next_arg_cnt;
   logic        push, fifo_ready, flush;
   logic [7:0]  push_data;

   // Loader hand-over.
   logic boot_err, next_boot_err, app_run, next_app_run;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
      end
      return r;
   endfunction

   // Byte of the recorder address space; unmapped bytes read zero.
   function automatic logic [7:0] store_byte(input logic [10:0] a);
      logic [10:0] o;
      logic [127:0] r;
      logic [31:0] w;
      o = 11'h000;
      r = '0;
      w = '0;
      store_byte = 8'h00;
      if (a == `FRUP_MAP_HDR) begin
         store_byte = {5'h00, rec_cnt};
      end else if (a == `FRUP_MAP_HDR + 11'h001) begin
         store_byte = {5'h00, wr_idx};
      end else if (a >= `FRUP_MAP_REC && a < `FRUP_MAP_BIN) begin
         o = a - `FRUP_MAP_REC;
         r = rec[o[6:4]];
         store_byte = r[8'(8'd127 - {o[3:0], 3'h0}) -: 8];
      end else if (a >= `FRUP_MAP_BIN && a < `FRUP_MAP_OCC) begin
         o = a - `FRUP_MAP_BIN;
         w = bin_time[o[4:2]];
         store_byte = w[5'(5'd31 - {o[1:0], 3'h0}) -: 8];
      end else if (a >= `FRUP_MAP_OCC && a < `FRUP_MAP_END) begin
         o = a - `FRUP_MAP_OCC;
         w = {occ_rec, occ_nonrec};
         store_byte = w[5'(5'd31 - {o[1:0], 3'h0}) -: 8];
      end
   endfunction

   // ----------------------------------------------------------------------
   // Recorder and statistics
   // ----------------------------------------------------------------------
   always_comb begin
      trig            = FAULT_REC_I || FAULT_NONREC_I;
      next_tick       = (tick == 32'(TICK_CYC - 1)) ? 32'h0 : tick + 32'h1;
      next_stamp      = (tick == 32'(TICK_CYC - 1)) ? stamp + 32'h1 : stamp;
      next_occ_rec    = occ_rec + 16'(FAULT_REC_I);
      next_occ_nonrec = occ_nonrec + 16'(FAULT_NONREC_I);
      next_wr_idx     = wr_idx;
      next_rec_cnt    = rec_cnt;
      next_stored     = trig;
      if (trig) begin
         next_wr_idx = (wr_idx == `FRUP_RECORDS - 3'h1) ? 3'h0 : wr_idx + 3'h1;
         if (rec_cnt != `FRUP_RECORDS) begin
            next_rec_cnt = rec_cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         tick          <= 32'h0;
         stamp         <= 32'h0;
         occ_rec       <= 16'h0;
         occ_nonrec    <= 16'h0;
         wr_idx        <= 3'h0;
         rec_cnt       <= 3'h0;
         SNAP_STORED_O <= 1'b0;
         for (int i = 0; i < 5; i++) begin
            rec[i] <= '0;
         end
         for (int i = 0; i < `FRUP_BINS; i++) begin
            bin_time[i] <= 32'h0;
         end
      end else begin
         tick          <= next_tick;
         stamp         <= next_stamp;
         occ_rec       <= next_occ_rec;
         occ_nonrec    <= next_occ_nonrec;
         wr_idx        <= next_wr_idx;
         rec_cnt       <= next_rec_cnt;
         SNAP_STORED_O <= next_stored;
         if (trig) begin
            rec[wr_idx] <= '{stamp: stamp, snap: SNAP_I};
         end
         if (tick == 32'(TICK_CYC - 1)) begin
            bin_time[LOAD_BIN_I] <= bin_time[LOAD_BIN_I] + 32'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Command interpreter
   // ----------------------------------------------------------------------
   always_comb begin
      next_state   = state;
      next_cmd     = cmd;
      next_len     = len;
      next_idx     = idx;
      next_crc     = crc;
      next_addr    = addr;
      next_arg_cnt = arg_cnt;
      push         = 1'b0;
      push_data    = 8'h00;
      flush        = 1'b0;
      if (LINK_I.stop) begin
         next_state = frup_pkg::ST_IDLE;
         flush      = 1'b1;
      end else if (LINK_I.start && !LINK_I.read) begin
         next_state = frup_pkg::ST_CMD;
         next_crc   = crc8(8'h00, {DEV_ADDR, 1'b0});
         flush      = 1'b1;
      end else begin
         case (state)
            frup_pkg::ST_CMD: begin
               if (LINK_I.wr_valid) begin
                  next_cmd     = LINK_I.wr_data;
                  next_crc     = crc8(crc, LINK_I.wr_data);
                  next_arg_cnt = 2'h0;
                  if (LINK_I.wr_data == `FRUP_CMD_UPLOAD) begin
                     next_state = frup_pkg::ST_ARG;
                  end else if (LINK_I.wr_data == `FRUP_CMD_ORDER) begin
                     next_state = frup_pkg::ST_WAIT_RD;
                  end else begin
                     next_state = frup_pkg::ST_IDLE;
                  end
               end
            end
            frup_pkg::ST_ARG: begin
               if (LINK_I.wr_valid) begin
                  next_crc     = crc8(crc, LINK_I.wr_data);
                  next_arg_cnt = arg_cnt + 2'h1;
                  case (arg_cnt)
                     2'h0: next_addr[15:8] = LINK_I.wr_data;
                     2'h1: next_addr[7:0]  = LINK_I.wr_data;
                     default: begin
                        next_len   = LINK_I.wr_data;
                        next_state = frup_pkg::ST_WAIT_RD;
                     end
                  endcase
               end
            end
            frup_pkg::ST_WAIT_RD: begin
               if (LINK_I.start && LINK_I.read) begin
                  next_crc   = crc8(crc, {DEV_ADDR, 1'b1});
                  next_idx   = 8'h00;
                  next_state = frup_pkg::ST_SEND;
                  if (cmd == `FRUP_CMD_ORDER) begin
                     next_len = `FRUP_ORDER_LEN;
                  end else if (len > `FRUP_MAX_LEN ||
                               17'(addr) + 17'(len) > `FRUP_STORE_BYTES) begin
                     next_len = 8'h00;
                  end
               end
            end
            frup_pkg::ST_SEND: begin
               if (fifo_ready) begin
                  push     = 1'b1;
                  next_idx = idx + 8'h01;
                  if (idx == 8'h00) begin
                     push_data = len;
                  end else if (idx <= len) begin
                     if (cmd == `FRUP_CMD_ORDER) begin
                        push_data = ORDER_CODE[7'(7'd95 - {idx[3:0], 3'h0}) -: 8];
                     end else begin
                        push_data = store_byte(11'(addr + 16'(idx) - 16'h1));
                     end
                  end else begin
                     push_data  = crc;
                     next_state = frup_pkg::ST_DONE;
                  end
                  if (idx <= len) begin
                     next_crc = crc8(crc, push_data);
                  end
               end
            end
            frup_pkg::ST_IDLE, frup_pkg::ST_DONE: begin
            end
            default: next_state = frup_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         state   <= frup_pkg::ST_IDLE;
         cmd     <= 8'h00;
         len     <= 8'h00;
         idx     <= 8'h00;
         crc     <= 8'h00;
         addr    <= 16'h0000;
         arg_cnt <= 2'h0;
      end else begin
         state   <= next_state;
         cmd     <= next_cmd;
         len     <= next_len;
         idx     <= next_idx;
         crc     <= next_crc;
         addr    <= next_addr;
         arg_cnt <= next_arg_cnt;
      end
   end

   frup_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (SYS_CLK_I),
      .rst_i       (RST_I),
      .flush_i     (flush),
      .in_valid_i  (push),
      .in_ready_o  (fifo_ready),
      .in_data_i   (push_data),
      .out_valid_o (TX_VALID_O),
      .out_ready_i (TX_READY_I),
      .out_data_o  (TX_DATA_O)
   );

   // ----------------------------------------------------------------------
   // Loader hand-over
   // ----------------------------------------------------------------------
   always_comb begin
      next_boot_err = BOOT_ERR_I || (boot_err && !BOOT_ENTER_I);
      next_app_run  = BOOT_ENTER_I ? 1'b0 : app_run;
      if (BOOT_EXIT_I && !boot_err && !BOOT_ERR_I) begin
         next_app_run = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         boot_err <= 1'b0;
         app_run  <= 1'b1;
      end else begin
         boot_err <= next_boot_err;
         app_run  <= next_app_run;
      end
   end

   assign APP_RUN_O = app_run;
endmodule

`default_nettype wire

// file: rtl/frup_regs.svh
/*
 * Constants of the fault record upload block: command codes, lengths, the
 * layout of the recorder's address space and the link timing figures.
 * Assumes a 10 MHz system clock; definitions only.
 */
// Operation
// - Loader keeps control when any reprogramming error was recorded; the code forgets errors recorded before the last BOOT_ENTER_I.
// - Failed transfer or missing data returns length zero, then PEC, then ends.
// - Up to five timestamped snapshots of status, alarms and measurements are kept.
// - A snapshot is stored when a recoverable or non-recoverable fault occurs.
// - With five slots full, a new snapshot replaces the oldest one.
// - Usage statistics count events and time per load range bin; the code counts events per fault class, only time per bin.
// - Upload write carries command, address high, address low, length up to 32.
// - Recorder contents are readable only through the upload command.
// - Ordering code answers count 11, eleven bytes, then PEC.
`ifndef FRUP_REGS_SVH
`define FRUP_REGS_SVH

`define FRUP_CMD_UPLOAD      8'hF0
`define FRUP_CMD_ORDER       8'hE8
`define FRUP_MAX_LEN         8'h20
`define FRUP_ORDER_LEN       8'h0B
`define FRUP_STORE_BYTES     17'h00800
`define FRUP_SEGMENTS        7'h40
`define FRUP_RECORDS         3'h5
`define FRUP_REC_BYTES       5'h10
`define FRUP_BINS            8

`define FRUP_MAP_HDR         11'h000
`define FRUP_MAP_REC         11'h010
`define FRUP_MAP_BIN         11'h060
`define FRUP_MAP_OCC         11'h080
`define FRUP_MAP_END         11'h084

`define FRUP_CLK_HZ          10000000
`define FRUP_TICK_MS         1
`define FRUP_TICK_CYC        ((`FRUP_CLK_HZ / 1000) * `FRUP_TICK_MS)
`define FRUP_HOST_RD_MS      2
`define FRUP_HOST_CMD_MS     30
`define FRUP_HOST_DFLT_MS    5000
`define FRUP_HOST_RETRY_MS   3000
`define FRUP_HOST_UPLOAD_MS  100

`endif

// file: rtl/frup_pkg.sv
/*
 * Types of the fault record upload block.
 * Assumes frup_regs.svh supplies the numeric constants.
 */
package frup_pkg;

   typedef struct packed {
      logic       start;
      logic       read;
      logic       wr_valid;
      logic [7:0] wr_data;
      logic       stop;
   } frup_link_type;

   typedef struct packed {
      logic [15:0] status;
      logic [15:0] alarm;
      logic [63:0] meas;
   } frup_snap_in_type;

   typedef struct packed {
      logic [31:0]      stamp;
      frup_snap_in_type snap;
   } frup_record_type;

   typedef enum logic [2:0] {
      ST_IDLE, ST_CMD, ST_ARG, ST_WAIT_RD, ST_SEND, ST_DONE
   } frup_state_type;

endpackage

// file: sim/frup_host.sv
/*
 * Host controller model on the management link of the fault record upload.
 * Assumes the bench calls xact and counts answer bytes itself.
 */
`timescale 1ns/100ps
`default_nettype none
module frup_host #(
   parameter int GAP = 10
) (
   input  wire logic                    clk_i,
   input  wire logic                    tx_valid_i,
   output var  frup_pkg::frup_link_type link_o,
   output var  logic                    tx_ready_o
);
   int seed = 83221;

   initial begin
      link_o = '0;
      tx_ready_o = 1'b0;
   end

   task automatic pulse(input frup_pkg::frup_link_type v);
      @(posedge clk_i);
      link_o <= v;
      @(posedge clk_i);
      link_o <= '0;
   endtask

   // ----------------------------------------------------------------
   // One command: write phase, read phase, stop
   // ----------------------------------------------------------------
   task automatic xact(input logic [7:0] c, input logic [7:0] a [3], input int na,
                       input int n, input logic slow);
      int got;
      int k;
      got = 0;
      k = 0;
      pulse('{1'b1, 1'b0, 1'b0, 8'h00, 1'b0});
      pulse('{1'b0, 1'b0, 1'b1, c, 1'b0});
      for (int j = 0; j < na; j++) begin
         pulse('{1'b0, 1'b0, 1'b1, a[j], 1'b0});
      end
      // Gaps are scaled down; the device does not time them.
      repeat (GAP) @(posedge clk_i);
      pulse('{1'b1, 1'b1, 1'b0, 8'h00, 1'b0});
      while (got < n && k < 4000) begin
         @(posedge clk_i);
         if (tx_valid_i && tx_ready_o) got++;
         tx_ready_o <= !(slow && (k < 24 || $random(seed) % 3 == 0));
         k++;
      end
      @(posedge clk_i);
      tx_ready_o <= 1'b1;
      repeat (GAP) @(posedge clk_i);
      tx_ready_o <= 1'b0;
      pulse('{1'b0, 1'b0, 1'b0, 8'h00, 1'b1});
      // The model never restores defaults and is always acknowledged, so the
      // longer waits after a defaults restore or an unanswered address never arise.
      repeat (GAP) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// file: sim/frup_top_chk.sv
/*
 * Port checker of frup_top, attached by bind.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
module frup_top_chk (
   input wire logic                    SYS_CLK_I,
   input wire logic                    RST_I,
   input wire frup_pkg::frup_link_type LINK_I,
   input wire logic                    TX_VALID_O,
   input wire logic                    FAULT_REC_I,
   input wire logic                    FAULT_NONREC_I,
   input wire logic                    SNAP_STORED_O,
   input wire logic                    BOOT_ENTER_I,
   input wire logic                    BOOT_ERR_I,
   input wire logic                    BOOT_EXIT_I,
   input wire logic                    APP_RUN_O
);
   logic err, next_err, arm, next_arm, ok, next_ok;

   always_comb begin
      next_err = BOOT_ERR_I | (err & ~BOOT_ENTER_I);
      next_arm = (LINK_I.start & ~LINK_I.read) | (arm & ~LINK_I.wr_valid);
      next_ok = ok;
      if (LINK_I.start && !LINK_I.read) next_ok = 1'b0;
      if (arm && LINK_I.wr_valid) next_ok = LINK_I.wr_data inside {8'hF0, 8'hE8};
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         err <= 1'b0;
         arm <= 1'b0;
         ok <= 1'b0;
      end else begin
         err <= next_err;
         arm <= next_arm;
         ok <= next_ok;
      end
   end

   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RST_I);

   a_snap_follows: assert property ((FAULT_REC_I || FAULT_NONREC_I) |=> SNAP_STORED_O)
      else $error("no snapshot pulse after a fault");
   a_snap_cause: assert property (SNAP_STORED_O |-> $past(FAULT_REC_I || FAULT_NONREC_I))
      else $error("snapshot pulse without a fault");
   a_loader_hold: assert property ((BOOT_EXIT_I && next_err && !APP_RUN_O) |=> !APP_RUN_O)
      else $error("application started after an error");
   a_loader_exit: assert property ((BOOT_EXIT_I && !next_err && !BOOT_ENTER_I) |=> APP_RUN_O)
      else $error("clean exit did not start the application");
   a_enter_loader: assert property ((BOOT_ENTER_I && !BOOT_EXIT_I) |=> !APP_RUN_O)
      else $error("loader entry left the application running");
   a_run_stable: assert property ((!BOOT_ENTER_I && !BOOT_EXIT_I) |=> $stable(APP_RUN_O))
      else $error("run state changed without a loader request");
   a_answer_first: assert property ((LINK_I.start && LINK_I.read && ok) |=> !TX_VALID_O ##1 TX_VALID_O)
      else $error("answer did not start two edges after the read start");
   a_no_answer: assert property ((LINK_I.start && LINK_I.read && !ok) |=> !TX_VALID_O [*8])
      else $error("answer to an unknown command");

   c_read: cover property (LINK_I.start && LINK_I.read && ok);
   c_snap: cover property (SNAP_STORED_O);
   c_run: cover property ($rose(APP_RUN_O));
endmodule

bind frup_top frup_top_chk u_frup_top_chk (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
   .LINK_I(LINK_I), .TX_VALID_O(TX_VALID_O), .FAULT_REC_I(FAULT_REC_I),
   .FAULT_NONREC_I(FAULT_NONREC_I), .SNAP_STORED_O(SNAP_STORED_O),
   .BOOT_ENTER_I(BOOT_ENTER_I), .BOOT_ERR_I(BOOT_ERR_I), .BOOT_EXIT_I(BOOT_EXIT_I),
   .APP_RUN_O(APP_RUN_O));
`default_nettype wire

// file: sim/test_fault_record_upload.sv
/*
 * Self-checking bench of frup_top with a host model on the link.
 * Assumes frup_host drives the link and the answer ready.
 */
`timescale 1ns/100ps
`default_nettype none
module test_fault_record_upload;
   localparam logic [6:0]  DA = 7'h2A;
   localparam logic [87:0] OC = 88'h0123456789ABCDEF012345; // Arbitrary value.
   logic                       clk, rst, txv, txr, stored, run, frec, fnon, ben, berr, bex;
   logic [7:0]                 txd;
   logic [2:0]                 bin;
   logic [95:0]                v;
   logic [31:0]                sa [6];
   frup_pkg::frup_link_type    lnk;
   frup_pkg::frup_snap_in_type snap;
   logic [7:0]                 exp_q [$];
   logic [7:0]                 q [$];
   logic [7:0]                 a [3];
   int                         fail_count, compares, seed;

   frup_top #(.DEV_ADDR(DA), .ORDER_CODE(OC), .TICK_CYC(4), .FIFO_DEPTH(16)) u_frup_top (
      .SYS_CLK_I(clk), .RST_I(rst), .LINK_I(lnk), .TX_VALID_O(txv), .TX_READY_I(txr),
      .TX_DATA_O(txd), .FAULT_REC_I(frec), .FAULT_NONREC_I(fnon), .SNAP_I(snap),
      .LOAD_BIN_I(bin), .SNAP_STORED_O(stored), .BOOT_ENTER_I(ben), .BOOT_ERR_I(berr),
      .BOOT_EXIT_I(bex), .APP_RUN_O(run));
   frup_host #(.GAP(10)) u_frup_host (.clk_i(clk), .tx_valid_i(txv), .link_o(lnk),
      .tx_ready_o(txr));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int k = 0; k < 8; k++) begin
         x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
      end
      return x;
   endfunction

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Command with expected answer q, PEC worked out here
   // ----------------------------------------------------------------
   task automatic cmd(input logic [7:0] c, input int na, input logic slow);
      logic [7:0] p;
      p = crc(crc(8'h00, {DA, 1'b0}), c);
      for (int k = 0; k < na; k++) p = crc(p, a[k]);
      p = crc(p, {DA, 1'b1});
      foreach (q[k]) begin
         p = crc(p, q[k]);
         exp_q.push_back(q[k]);
      end
      if (q.size() > 0) exp_q.push_back(p);
      u_frup_host.xact(c, a, na, q.size() ? q.size() + 1 : 0, slow);
   endtask

   task automatic up(input logic [7:0] ah, input logic [7:0] al, input logic [7:0] n);
      a = '{ah, al, n};
      cmd(8'hF0, 3, 1'b1);
   endtask

   task automatic fault(input int s);
      v = {$random(seed), $random(seed), $random(seed)};
      sa[s] = v[95:64];
      @(posedge clk);
      snap <= v;
      bin <= 3'($random(seed));
      frec <= s % 2 == 0;
      fnon <= s % 2 != 0;
      @(posedge clk);
      frec <= 1'b0;
      fnon <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic boot(input logic e, input logic r, input logic x);
      @(posedge clk);
      ben <= e;
      berr <= r;
      bex <= x;
      @(posedge clk);
      {ben, berr, bex} <= 3'h0;
      @(posedge clk);
   endtask

   always @(posedge clk) begin
      if (txv === 1'b1 && txr === 1'b1) cmp(txd, exp_q.size() ? exp_q.pop_front() : 8'hXX);
   end

   initial begin
      #3000000;
      fail_count++;
      $display("wrong value at %0t: watchdog ran out", $time);
      conclude;
   end

   initial begin
      seed = 83221;
      {rst, frec, fnon, ben, berr, bex, bin, snap} = '0;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      q = {8'h0B};
      for (int k = 10; k >= 0; k--) q.push_back(OC[k*8+:8]);
      cmd(8'hE8, 0, 1'b0);
      q = {8'h02, 8'h00, 8'h00};
      up(8'h00, 8'h00, 8'h02);
      q = {8'h00};
      up(8'h00, 8'h00, 8'h21);
      up(8'h07, 8'hF0, 8'h20);
      q = {8'h20};
      repeat (32) q.push_back(8'h00);
      up(8'h07, 8'hE0, 8'h20);
      q = {};
      cmd(8'h55, 0, 1'b0);
      for (int s = 0; s < 6; s++) fault(s);
      q = {8'h02, 8'h05, 8'h01};
      up(8'h00, 8'h00, 8'h02);
      q = {8'h04, sa[5][31:24], sa[5][23:16], sa[5][15:8], sa[5][7:0]};
      up(8'h00, 8'h14, 8'h04);
      q = {8'h04, sa[1][31:24], sa[1][23:16], sa[1][15:8], sa[1][7:0]};
      up(8'h00, 8'h24, 8'h04);
      q = {8'h04, 8'h00, 8'h03, 8'h00, 8'h03};
      up(8'h00, 8'h80, 8'h04);
      boot(1'b1, 1'b0, 1'b0);
      cmp({7'h00, run}, 8'h00);
      boot(1'b0, 1'b1, 1'b0);
      boot(1'b0, 1'b0, 1'b1);
      cmp({7'h00, run}, 8'h00);
      boot(1'b1, 1'b0, 1'b0);
      boot(1'b0, 1'b0, 1'b1);
      cmp({7'h00, run}, 8'h01);
      cmp(8'(exp_q.size()), 8'h00);
      conclude;
   end
endmodule
`default_nettype wire
